// ---- fsu_pkg.sv ----
// What this block does
// - Commands act only in self-update mode; writing the command register starts them.
// - All commands but chip erase refused when the addressed block is locked.
// - Erase and program timing comes from internal counters, not software.
// - Chip erase clears both blocks, security and re-map bytes, ignoring locks.
// - Chip erase needs data 55h, then setup byte, then code 87h or 07h.
// - Setup byte 5Dh or DDh must precede every program or erase code.
// - Code bit 7 set pulses interrupt line one at completion; clear means polling.
// - Block erase target is address-high bit 7: 0 primary, 1 secondary.
// - Block erase needs block address, data 55h, setup, code 8Fh or 0Fh.
// - Sector erase covers 128 bytes in primary, 64 bytes from F000h upward.
// - Sector erase uses address regs, setup, code 8Bh or 0Bh; data ignored.
// - Byte program uses address, data, setup, code 8Eh or 0Eh; one byte.
// - Burst program uses address, data, setup, code 8Ah or 0Ah; row bytes.
// - Verify takes address and code 8Ch or 0Ch, no setup; returns byte.
// - Status bit 3 stays set while an operation runs; software polls it.
// - A byte program finishes within 97 microseconds.
// - Codes but verify ignored without setup; setup consumed by any command but verify, cancelled by events.
package fsu_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_FLASH_COMMAND = 8'hb2;
  localparam logic [7:0] ADDR_FLASH_ADDRESS_LOW = 8'hb3;
  localparam logic [7:0] ADDR_FLASH_ADDRESS_HIGH = 8'hb4;
  localparam logic [7:0] ADDR_FLASH_DATA_BUFFER = 8'hb5;
  localparam logic [7:0] ADDR_FLASH_CONFIG_STATUS = 8'hb6;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Field positions
  localparam int BUSY_BIT = 3;
  localparam int IRQ_SELECT_BIT = 7;
  localparam int TOP_ADDRESS_BIT = 15;
  // Operation codes, low seven bits
  localparam logic [6:0] OP_SETUP = 7'h5d;
  localparam logic [6:0] OP_CHIP_ERASE = 7'h07;
  localparam logic [6:0] OP_BLOCK_ERASE = 7'h0f;
  localparam logic [6:0] OP_SECTOR_ERASE = 7'h0b;
  localparam logic [6:0] OP_BYTE_PROGRAM = 7'h0e;
  localparam logic [6:0] OP_BURST_PROGRAM = 7'h0a;
  localparam logic [6:0] OP_VERIFY = 7'h0c;
  localparam logic [7:0] ERASE_KEY = 8'h55;
  // Address layout
  localparam logic [15:0] SECONDARY_BASE = 16'hf000;
  localparam logic [15:0] PRIMARY_SECTOR_MASK = 16'hff80;
  localparam logic [15:0] SECONDARY_SECTOR_MASK = 16'hffc0;
  // Timing
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int CHIP_ERASE_NS = 4250000;
  localparam int BLOCK_ERASE_NS = 4250000;
  localparam int SECTOR_ERASE_NS = 1100000;
  localparam int BYTE_PROGRAM_MAX_NS = 97000;
  localparam int BURST_BYTE_MIN_NS = 31000;
  localparam int CHIP_ERASE_CYC = (CHIP_ERASE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int BLOCK_ERASE_CYC = (BLOCK_ERASE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SECTOR_ERASE_CYC = (SECTOR_ERASE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int BYTE_PROGRAM_CYC = BYTE_PROGRAM_MAX_NS / CLOCK_PERIOD_NS;
  localparam int BURST_BYTE_CYC = (BURST_BYTE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int COUNT_W = 20;
  // Operation driven to the flash array
  typedef enum logic [2:0] {
    FSU_OP_NONE = 3'h0,
    FSU_OP_CHIP_ERASE = 3'h1,
    FSU_OP_BLOCK_ERASE = 3'h2,
    FSU_OP_SECTOR_ERASE = 3'h3,
    FSU_OP_PROGRAM = 3'h4,
    FSU_OP_READ = 3'h5
  } fsu_op_e;
  // Sequencer states
  typedef enum logic [2:0] {
    FSU_IDLE = 3'b001,
    FSU_RUN = 3'b010,
    FSU_VERIFY = 3'b100
  } fsu_state_e;
endpackage : fsu_pkg

// ---- fsu_sequencer.sv ----
`timescale 1ns/1ps
module fsu_sequencer #(
  parameter int CHIP_ERASE_CYCLES = fsu_pkg::CHIP_ERASE_CYC,
  parameter int BLOCK_ERASE_CYCLES = fsu_pkg::BLOCK_ERASE_CYC,
  parameter int SECTOR_ERASE_CYCLES = fsu_pkg::SECTOR_ERASE_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic self_update_mode,
  input wire logic setup_cancel,
  input wire logic lock_primary,
  input wire logic lock_secondary,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output fsu_pkg::fsu_op_e flash_op,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_rdata,
  output logic busy,
  output logic external_irq_line_one
);
  import fsu_pkg::*;

  fsu_state_e state, next_state;
  logic [COUNT_W-1:0] count, next_count;
  logic setup_pending, next_setup_pending;
  logic irq_select, next_irq_select;
  logic [7:0] flash_address_high, next_flash_address_high;
  logic [7:0] flash_address_low, next_flash_address_low;
  logic [7:0] flash_data_buffer, next_flash_data_buffer;
  logic [7:0] flash_command, next_flash_command;
  fsu_op_e next_flash_op;
  logic [15:0] next_flash_addr;
  logic [7:0] next_flash_wdata;
  logic [7:0] next_sfr_rdata;
  logic next_irq;
  logic [15:0] target;
  logic target_secondary;
  logic target_locked;
  logic cmd_write;
  logic [6:0] op_code;

  // Decode of the addressed location for the incoming command
  assign target = {flash_address_high, flash_address_low};
  assign target_secondary = (target >= SECONDARY_BASE);
  assign op_code = sfr_wdata[6:0];
  assign cmd_write = sfr_wr && (sfr_addr == ADDR_FLASH_COMMAND) && self_update_mode
                     && (state == FSU_IDLE);

  // Block erase picks its block from the top address bit, others from the range
  always_comb begin
    if (op_code == OP_BLOCK_ERASE) begin
      target_locked = target[TOP_ADDRESS_BIT] ? lock_secondary : lock_primary;
    end else begin
      target_locked = target_secondary ? lock_secondary : lock_primary;
    end
  end

  // Mailbox registers, command decode and operation timing
  always_comb begin
    next_state = state;
    next_count = count;
    next_setup_pending = setup_pending;
    next_irq_select = irq_select;
    next_flash_address_high = flash_address_high;
    next_flash_address_low = flash_address_low;
    next_flash_data_buffer = flash_data_buffer;
    next_flash_command = flash_command;
    next_flash_op = flash_op;
    next_flash_addr = flash_addr;
    next_flash_wdata = flash_wdata;
    next_irq = 1'b0;
    // Plain register writes
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_FLASH_ADDRESS_HIGH: next_flash_address_high = sfr_wdata;
        ADDR_FLASH_ADDRESS_LOW: next_flash_address_low = sfr_wdata;
        ADDR_FLASH_DATA_BUFFER: next_flash_data_buffer = sfr_wdata;
        default: ;
      endcase
    end
    // Command decode while idle, then the timed operation in progress
    case (state)
      FSU_IDLE: begin
        if (cmd_write) begin
          next_flash_command = sfr_wdata;
          next_irq_select = sfr_wdata[IRQ_SELECT_BIT];
          next_setup_pending = 1'b0;
          if (op_code == OP_SETUP) begin
            next_setup_pending = 1'b1;
          end else if (op_code == OP_VERIFY) begin
            next_setup_pending = setup_pending;
            if (!target_locked) begin
              next_flash_op = FSU_OP_READ;
              next_flash_addr = target;
              next_state = FSU_VERIFY;
            end
          end else if (setup_pending) begin
            case (op_code)
              OP_CHIP_ERASE: begin
                if (flash_data_buffer == ERASE_KEY) begin
                  next_flash_op = FSU_OP_CHIP_ERASE;
                  next_flash_addr = 16'h0000;
                  next_count = COUNT_W'(CHIP_ERASE_CYCLES);
                  next_state = FSU_RUN;
                end
              end
              OP_BLOCK_ERASE: begin
                if (flash_data_buffer == ERASE_KEY && !target_locked) begin
                  next_flash_op = FSU_OP_BLOCK_ERASE;
                  next_flash_addr = target[TOP_ADDRESS_BIT] ? SECONDARY_BASE : 16'h0000;
                  next_count = COUNT_W'(BLOCK_ERASE_CYCLES);
                  next_state = FSU_RUN;
                end
              end
              OP_SECTOR_ERASE: begin
                if (!target_locked) begin
                  next_flash_op = FSU_OP_SECTOR_ERASE;
                  next_flash_addr = target & (target_secondary ? SECONDARY_SECTOR_MASK
                                                               : PRIMARY_SECTOR_MASK);
                  next_count = COUNT_W'(SECTOR_ERASE_CYCLES);
                  next_state = FSU_RUN;
                end
              end
              OP_BYTE_PROGRAM, OP_BURST_PROGRAM: begin
                if (!target_locked) begin
                  next_flash_op = FSU_OP_PROGRAM;
                  next_flash_addr = target;
                  next_flash_wdata = flash_data_buffer;
                  next_count = (op_code == OP_BYTE_PROGRAM) ? COUNT_W'(BYTE_PROGRAM_CYC)
                                                            : COUNT_W'(BURST_BYTE_CYC);
                  next_state = FSU_RUN;
                end
              end
              default: ;
            endcase
          end
        end
      end
      FSU_RUN: begin
        next_count = count - COUNT_W'(1);
        if (count == COUNT_W'(1)) begin
          next_state = FSU_IDLE;
          next_flash_op = FSU_OP_NONE;
          next_irq = irq_select;
        end
      end
      FSU_VERIFY: begin
        next_flash_data_buffer = flash_rdata;
        next_flash_op = FSU_OP_NONE;
        next_irq = irq_select;
        next_state = FSU_IDLE;
      end
      default: begin
        next_state = FSU_IDLE;
        next_flash_op = FSU_OP_NONE;
      end
    endcase
    // Outside events drop an armed setup byte
    if (setup_cancel) begin
      next_setup_pending = 1'b0;
    end
  end

  // Read data mux, registered
  always_comb begin
    case (sfr_addr)
      ADDR_FLASH_COMMAND: next_sfr_rdata = flash_command;
      ADDR_FLASH_ADDRESS_LOW: next_sfr_rdata = flash_address_low;
      ADDR_FLASH_ADDRESS_HIGH: next_sfr_rdata = flash_address_high;
      ADDR_FLASH_DATA_BUFFER: next_sfr_rdata = flash_data_buffer;
      ADDR_FLASH_CONFIG_STATUS: begin
        next_sfr_rdata = RESET_BYTE;
        next_sfr_rdata[BUSY_BIT] = (state != FSU_IDLE);
      end
      default: next_sfr_rdata = RESET_BYTE;
    endcase
  end

  // State registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= FSU_IDLE;
      count <= '0;
      setup_pending <= 1'b0;
      irq_select <= 1'b0;
      flash_address_high <= RESET_BYTE;
      flash_address_low <= RESET_BYTE;
      flash_data_buffer <= RESET_BYTE;
      flash_command <= RESET_BYTE;
      flash_op <= FSU_OP_NONE;
      flash_addr <= 16'h0000;
      flash_wdata <= RESET_BYTE;
      sfr_rdata <= RESET_BYTE;
      external_irq_line_one <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      setup_pending <= next_setup_pending;
      irq_select <= next_irq_select;
      flash_address_high <= next_flash_address_high;
      flash_address_low <= next_flash_address_low;
      flash_data_buffer <= next_flash_data_buffer;
      flash_command <= next_flash_command;
      flash_op <= next_flash_op;
      flash_addr <= next_flash_addr;
      flash_wdata <= next_flash_wdata;
      sfr_rdata <= next_sfr_rdata;
      external_irq_line_one <= next_irq;
    end
  end

  // Busy flag seen by the system
  assign busy = (state != FSU_IDLE);

  // Checks
  a_mode_gates_start: assert property (@(posedge clock) disable iff (sys_rst)
    (state == FSU_IDLE && !self_update_mode) |=> (state == FSU_IDLE))
    else $error("operation started outside self-update mode");
  a_lock_refuses_sector: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && op_code == OP_SECTOR_ERASE && target_locked) |=> (state == FSU_IDLE))
    else $error("sector erase started on locked block");
  a_chip_erase_length: assert property (@(posedge clock) disable iff (sys_rst)
    (state == FSU_IDLE && next_flash_op == FSU_OP_CHIP_ERASE)
    |=> (count == COUNT_W'(CHIP_ERASE_CYCLES)) && busy)
    else $error("chip erase not loaded with its length");
  a_setup_required: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && !setup_pending && op_code != OP_VERIFY) |=> (state == FSU_IDLE))
    else $error("operation started without setup byte");
  a_irq_on_done: assert property (@(posedge clock) disable iff (sys_rst)
    (state == FSU_RUN && count == COUNT_W'(1)) |=> (external_irq_line_one == irq_select))
    else $error("completion interrupt wrong");
  a_sector_aligned: assert property (@(posedge clock) disable iff (sys_rst)
    (flash_op == FSU_OP_SECTOR_ERASE) |-> (flash_addr[5:0] == 6'h00)
    && (flash_addr >= SECONDARY_BASE || flash_addr[6] == 1'b0))
    else $error("sector address not aligned");
  a_byte_prog_time: assert property (@(posedge clock) disable iff (sys_rst)
    (state == FSU_IDLE && next_count == COUNT_W'(BYTE_PROGRAM_CYC) && next_state == FSU_RUN)
    |=> busy [*8] ##[1:970] !busy)
    else $error("byte program outside its time");
  a_verify_returns: assert property (@(posedge clock) disable iff (sys_rst)
    (state == FSU_VERIFY) |=> (flash_data_buffer == $past(flash_rdata)) && !busy)
    else $error("verify byte not returned");
  a_setup_consumed: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && op_code != OP_SETUP && op_code != OP_VERIFY) |=> !setup_pending)
    else $error("setup byte not consumed");
  a_busy_ignores: assert property (@(posedge clock) disable iff (sys_rst)
    (busy && sfr_wr && sfr_addr == ADDR_FLASH_COMMAND) |=> $stable(flash_command))
    else $error("command taken while busy");
  // Lock refusals for the remaining commands
  a_lock_refuses_block: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && op_code == OP_BLOCK_ERASE && target_locked) |=> (state == FSU_IDLE))
    else $error("block erase started on locked block");
  a_lock_refuses_program: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && (op_code == OP_BYTE_PROGRAM || op_code == OP_BURST_PROGRAM) && target_locked)
    |=> (state == FSU_IDLE))
    else $error("program started on locked block");
  a_lock_refuses_verify: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && op_code == OP_VERIFY && target_locked) |=> (state == FSU_IDLE))
    else $error("verify started on locked block");
  // Chip and block erases need their key; chip erase ignores locks
  a_chip_ignores_lock: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && setup_pending && op_code == OP_CHIP_ERASE
     && flash_data_buffer == ERASE_KEY)
    |=> (flash_op == FSU_OP_CHIP_ERASE) && (flash_addr == 16'h0000))
    else $error("chip erase did not start");
  a_chip_key_needed: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && op_code == OP_CHIP_ERASE && flash_data_buffer != ERASE_KEY)
    |=> (state == FSU_IDLE))
    else $error("chip erase started without key");
  a_block_key_needed: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && op_code == OP_BLOCK_ERASE && flash_data_buffer != ERASE_KEY)
    |=> (state == FSU_IDLE))
    else $error("block erase started without key");
  a_block_target: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && setup_pending && op_code == OP_BLOCK_ERASE && flash_data_buffer == ERASE_KEY
     && !target_locked) |=> (flash_op == FSU_OP_BLOCK_ERASE)
    && (flash_addr == ($past(target[TOP_ADDRESS_BIT]) ? SECONDARY_BASE : 16'h0000)))
    else $error("block erase target wrong");
  // Run lengths, data, status busy bit and completion interrupt come from internal state only
  a_sector_length: assert property (@(posedge clock) disable iff (sys_rst)
    (state == FSU_IDLE && next_flash_op == FSU_OP_SECTOR_ERASE)
    |=> (count == COUNT_W'(SECTOR_ERASE_CYCLES)) && busy)
    else $error("sector erase not loaded with its length");
  a_burst_length: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_write && setup_pending && op_code == OP_BURST_PROGRAM && !target_locked)
    |=> (count == COUNT_W'(BURST_BYTE_CYC)) && busy)
    else $error("burst byte not loaded with its length");
  a_run_counts_down: assert property (@(posedge clock) disable iff (sys_rst)
    (state == FSU_RUN && count != COUNT_W'(1))
    |=> (state == FSU_RUN) && (count == $past(count) - COUNT_W'(1)))
    else $error("operation counter did not step");
  a_program_data: assert property (@(posedge clock) disable iff (sys_rst)
    (state == FSU_IDLE && next_flash_op == FSU_OP_PROGRAM)
    |=> (flash_wdata == $past(flash_data_buffer)) && (flash_addr == $past(target)))
    else $error("program data or address wrong");
  a_status_busy: assert property (@(posedge clock) disable iff (sys_rst)
    (sfr_addr == ADDR_FLASH_CONFIG_STATUS) |=> (sfr_rdata[BUSY_BIT] == $past(busy)))
    else $error("status busy bit wrong");
  a_irq_only_done: assert property (@(posedge clock) disable iff (sys_rst)
    external_irq_line_one |-> (state == FSU_IDLE) && ($past(state) != FSU_IDLE))
    else $error("interrupt without completion");
endmodule : fsu_sequencer

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import fsu_pkg::*;
  logic clock, sys_rst, self_update_mode, setup_cancel, lock_primary, lock_secondary;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, flash_wdata, flash_rdata, rd_val;
  logic sfr_wr, busy, external_irq_line_one;
  fsu_op_e flash_op;
  logic [15:0] flash_addr;
  int error_cnt = 0;
  int compares = 0;
  int irq_cnt = 0;
  int i0, n;

  // Short erase counts keep the run brief
  fsu_sequencer #(
    .CHIP_ERASE_CYCLES(20),
    .BLOCK_ERASE_CYCLES(20),
    .SECTOR_ERASE_CYCLES(20)
  ) u_fsu_sequencer (
    .clock(clock), .sys_rst(sys_rst), .self_update_mode(self_update_mode),
    .setup_cancel(setup_cancel), .lock_primary(lock_primary),
    .lock_secondary(lock_secondary), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_op(flash_op),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
    .busy(busy), .external_irq_line_one(external_irq_line_one)
  );

  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Count completion pulses
  always @(posedge clock) begin
    if (external_irq_line_one === 1'b1) irq_cnt++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // One register write; a gap cycle follows so the strobe drops cleanly
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    sfr_addr = a;
    @(negedge clock);
    rd_val = sfr_rdata;
  endtask : rd

  // Setup byte followed by an operation code
  task automatic launch(input logic [7:0] code);
    wr(ADDR_FLASH_COMMAND, 8'h5d);
    wr(ADDR_FLASH_COMMAND, code);
  endtask : launch

  task automatic expect_op(input fsu_op_e op, input logic [15:0] a);
    check(busy, 1'b1);
    check(flash_op, op);
    check(flash_addr, a);
  endtask : expect_op

  // Poll busy, bounded, then confirm the run fitted its budget
  task automatic idle(input int lim);
    n = 0;
    while (busy !== 1'b0 && n < 50000) begin
      @(negedge clock);
      n++;
    end
    check(n > 0 && n <= lim, 1'b1);
    repeat (2) @(negedge clock);
    check(flash_op, FSU_OP_NONE);
  endtask : idle

  // Hang guard
  initial begin
    #1000000;
    error_cnt++;
    test_done;
  end

  initial begin
    sys_rst = 1'b1;
    // Bench code runs outside the array, so any block may be written
    self_update_mode = 1'b1;
    setup_cancel = 1'b0;
    lock_primary = 1'b0;
    lock_secondary = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    flash_rdata = 8'h00;
    repeat (4) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    check(busy, 1'b0);
    rd(ADDR_FLASH_CONFIG_STATUS);
    check(rd_val, 8'h00);
    // Byte program with interrupt completion
    wr(ADDR_FLASH_ADDRESS_HIGH, 8'h12);
    wr(ADDR_FLASH_ADDRESS_LOW, 8'h34);
    wr(ADDR_FLASH_DATA_BUFFER, 8'haa);
    i0 = irq_cnt;
    launch(8'h8e);
    expect_op(FSU_OP_PROGRAM, 16'h1234);
    check(flash_wdata, 8'haa);
    rd(ADDR_FLASH_CONFIG_STATUS);
    check(rd_val, 8'h08);
    wr(ADDR_FLASH_COMMAND, 8'h0c);
    rd(ADDR_FLASH_COMMAND);
    check(rd_val, 8'h8e);
    check(flash_op, FSU_OP_PROGRAM);
    idle(970);
    check(irq_cnt - i0 == 1, 1'b1);
    // Refusals: no setup, undefined code, cancel, outside mode
    wr(ADDR_FLASH_COMMAND, 8'h0e);
    check(busy, 1'b0);
    launch(8'h33);
    wr(ADDR_FLASH_COMMAND, 8'h0e);
    check(busy, 1'b0);
    wr(ADDR_FLASH_COMMAND, 8'hdd);
    setup_cancel = 1'b1;
    @(negedge clock);
    setup_cancel = 1'b0;
    wr(ADDR_FLASH_COMMAND, 8'h0e);
    check(busy, 1'b0);
    self_update_mode = 1'b0;
    launch(8'h0e);
    check(busy, 1'b0);
    self_update_mode = 1'b1;
    // Chip erase: key, then locks ignored, polling only
    wr(ADDR_FLASH_DATA_BUFFER, 8'h54);
    launch(8'h07);
    check(busy, 1'b0);
    lock_primary = 1'b1;
    lock_secondary = 1'b1;
    wr(ADDR_FLASH_DATA_BUFFER, 8'h55);
    i0 = irq_cnt;
    launch(8'h07);
    expect_op(FSU_OP_CHIP_ERASE, 16'h0000);
    idle(20);
    check(irq_cnt == i0, 1'b1);
    // Block erase: locked primary refused, secondary and primary targets
    wr(ADDR_FLASH_ADDRESS_HIGH, 8'h00);
    launch(8'h0f);
    check(busy, 1'b0);
    lock_secondary = 1'b0;
    wr(ADDR_FLASH_ADDRESS_HIGH, 8'h80);
    launch(8'h8f);
    expect_op(FSU_OP_BLOCK_ERASE, SECONDARY_BASE);
    idle(20);
    lock_primary = 1'b0;
    wr(ADDR_FLASH_DATA_BUFFER, 8'h54);
    launch(8'h0f);
    check(busy, 1'b0);
    wr(ADDR_FLASH_DATA_BUFFER, 8'h55);
    wr(ADDR_FLASH_ADDRESS_HIGH, 8'h00);
    launch(8'h0f);
    expect_op(FSU_OP_BLOCK_ERASE, 16'h0000);
    idle(20);
    // Sector erase in both blocks
    wr(ADDR_FLASH_ADDRESS_HIGH, 8'h12);
    wr(ADDR_FLASH_ADDRESS_LOW, 8'h34);
    launch(8'h0b);
    expect_op(FSU_OP_SECTOR_ERASE, 16'h1200);
    idle(20);
    wr(ADDR_FLASH_ADDRESS_HIGH, 8'hf0);
    wr(ADDR_FLASH_ADDRESS_LOW, 8'hff);
    lock_secondary = 1'b1;
    launch(8'h8b);
    check(busy, 1'b0);
    lock_secondary = 1'b0;
    wr(ADDR_FLASH_COMMAND, 8'hdd);
    wr(ADDR_FLASH_COMMAND, 8'h8b);
    expect_op(FSU_OP_SECTOR_ERASE, 16'hf0c0);
    idle(20);
    // Burst program, two bytes in one row already cleared by the sector erase
    wr(ADDR_FLASH_ADDRESS_HIGH, 8'h12);
    wr(ADDR_FLASH_ADDRESS_LOW, 8'h34);
    wr(ADDR_FLASH_DATA_BUFFER, 8'h5a);
    launch(8'h0a);
    expect_op(FSU_OP_PROGRAM, 16'h1234);
    idle(310);
    wr(ADDR_FLASH_ADDRESS_LOW, 8'h35);
    wr(ADDR_FLASH_DATA_BUFFER, 8'ha5);
    launch(8'h0a);
    expect_op(FSU_OP_PROGRAM, 16'h1235);
    check(flash_wdata, 8'ha5);
    idle(310);
    // Verify returns the array byte, no setup needed
    flash_rdata = 8'h3c;
    wr(ADDR_FLASH_ADDRESS_LOW, 8'h34);
    i0 = irq_cnt;
    wr(ADDR_FLASH_COMMAND, 8'h8c);
    expect_op(FSU_OP_READ, 16'h1234);
    idle(1);
    rd(ADDR_FLASH_DATA_BUFFER);
    check(rd_val, 8'h3c);
    check(irq_cnt - i0 == 1, 1'b1);
    lock_primary = 1'b1;
    wr(ADDR_FLASH_COMMAND, 8'h0c);
    check(busy, 1'b0);
    launch(8'h0e);
    check(busy, 1'b0);
    lock_primary = 1'b0;
    test_done;
  end
endmodule : tb_top
